// ==== hw/prs_switch_ctrl.v ====
// Reference clock switchover, bandwidth select and phase control logic
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "prs_switch_map.vh"

// How it works
// RQ1: Primary reference selected after reset.
// RQ2: Switch after rise plus three high cycles.
// RQ3: Request must return low before next switch.
// RQ4: Request held three cycles of slower clock; the code counts three rises of the selected reference, slower or not.
// RQ5: Request only while both clocks toggle.
// RQ6: Loss flags valid only within 2x ratio.
// RQ7: Reset PLL, gate outputs until lock; the code has no lock input and the output enables follow only i_out_gate_en.
// RQ8: Detector disable holds VCO frequency.
// RQ9: Gate enables suppress output clocks.
// RQ10: Three bandwidth settings, medium by default.
// RQ11: Any counter takes any of eight taps.
// RQ12: Counter start delayed start count minus one.
// RQ13: Phase steps by taps, one step clock.
// RQ14: Gate on old fall, switch on new fall.
// RQ15: Indicator follows request; no loss while running.
// RQ16: Wait while target clock is absent.
// RQ17: Request synchronised before counting high time.
// RQ18: Ignore new requests until switch settled.
module prs_switch_ctrl (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_primary_ref_clock,
   input wire i_backup_ref_clock,
   input wire i_switch_req,
   input wire i_phase_detector_enable,
   input wire [3:0] i_out_gate_en,
   input wire i_phase_step_clk,
   input wire i_vco_tick,
   input wire i_counter_restart,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   output reg o_ref_sel,
   output reg o_ref_gate,
   output reg o_loss_primary,
   output reg o_loss_backup,
   output reg o_vco_hold,
   output reg [3:0] o_out_clk_en,
   output reg [1:0] o_bw_code,
   output reg [11:0] o_tap_sel,
   output reg [3:0] o_cnt_run
);

   localparam ST_IDLE = 3'h0;
   localparam ST_QUAL = 3'h1;
   localparam ST_GATE = 3'h2;
   localparam ST_WAIT_NEW = 3'h3;
   localparam ST_WAIT_LOW = 3'h4;
   localparam NP = 9;
   localparam integer LOSS_INT = `PRS_LOSS_CYC;
   localparam [7:0] LOSS_CYC = LOSS_INT[7:0];
   // Detector enable idles high, so its stages reset high to avoid a false hold after reset
   localparam [NP-1:0] SYNC_RST = 9'h008;

   // Unknown codes fall back to medium so the loop always has a valid setting
   function [1:0] bw_norm;
      input [1:0] code;
      begin
         if (code == `PRS_BW_LOW || code == `PRS_BW_HIGH) begin
            bw_norm = code;
         end else begin
            bw_norm = `PRS_BW_MED;
         end
      end
   endfunction

   function phase_hit;
      input [7:0] addr;
      begin
         phase_hit = (addr >= `PRS_ADDR_PHASE0) && (addr <= `PRS_ADDR_PHASE_LAST)
            && (addr[1:0] == 2'h0);
      end
   endfunction

   // Pin inputs: three stages, a change is taken once stages two and three agree
   wire [NP-1:0] pins_in;
   reg [NP-1:0] s1_reg;
   reg [NP-1:0] s2_reg;
   reg [NP-1:0] s3_reg;
   reg [NP-1:0] q_reg;
   reg [NP-1:0] qd_reg;
   wire [NP-1:0] q_next;
   assign pins_in = {i_out_gate_en, i_phase_step_clk, i_phase_detector_enable,
      i_switch_req, i_backup_ref_clock, i_primary_ref_clock};
   assign q_next = (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         s1_reg <= SYNC_RST;
         s2_reg <= SYNC_RST;
         s3_reg <= SYNC_RST;
         q_reg <= SYNC_RST;
         qd_reg <= SYNC_RST;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
         qd_reg <= q_reg;
      end
   end

   wire [1:0] ref_q;
   wire [1:0] ref_rise;
   wire [1:0] ref_fall;
   wire req_q;
   wire req_rise;
   wire pfd_q;
   wire step_rise;
   assign ref_q = q_reg[1:0];
   assign ref_rise = q_reg[1:0] & ~qd_reg[1:0];
   assign ref_fall = ~q_reg[1:0] & qd_reg[1:0];
   assign req_q = q_reg[2];
   assign req_rise = q_reg[2] & ~qd_reg[2];
   assign pfd_q = q_reg[3];
   assign step_rise = q_reg[4] & ~qd_reg[4];

   // Loss detectors: a reference with no edge for the limit is flagged.
   // The limit only makes sense when the two periods are within 2x. [RQ6]
   reg [7:0] idle_cnt_reg [0:1];
   reg [1:0] loss_reg;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_loss
         always @(posedge i_clk) begin
            if (!i_rst_b) begin
               idle_cnt_reg[g] <= 8'h00;
               loss_reg[g] <= 1'b0;
            end else if (ref_rise[g] || ref_fall[g]) begin
               idle_cnt_reg[g] <= 8'h00;
               loss_reg[g] <= 1'b0; // [RQ15]
            end else if (idle_cnt_reg[g] < LOSS_CYC) begin
               idle_cnt_reg[g] <= idle_cnt_reg[g] + 8'h01;
            end else begin
               loss_reg[g] <= 1'b1; // [RQ6]
            end
         end
      end
   endgenerate

   // Switchover sequencer
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg sel_reg;
   reg sel_next;
   reg gate_reg;
   reg gate_next;
   reg [1:0] hi_cnt_reg;
   reg [1:0] hi_cnt_next;
   reg sw_done_reg;
   reg sw_done_next;
   wire old_fall;
   wire new_fall;
   wire cur_rise;
   assign old_fall = sel_reg ? ref_fall[1] : ref_fall[0];
   assign new_fall = sel_reg ? ref_fall[0] : ref_fall[1];
   assign cur_rise = sel_reg ? ref_rise[1] : ref_rise[0];

   always @* begin
      state_next = state_reg;
      sel_next = sel_reg;
      gate_next = gate_reg;
      hi_cnt_next = hi_cnt_reg;
      sw_done_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            hi_cnt_next = 2'h0;
            if (req_rise) begin // [RQ2]
               state_next = ST_QUAL;
            end
         end
         ST_QUAL: begin
            // High time counted in edges of the selected reference [RQ17]
            if (!req_q) begin
               state_next = ST_IDLE;
            end else if (cur_rise) begin
               hi_cnt_next = hi_cnt_reg + 2'h1;
               if (hi_cnt_reg + 2'h1 == `PRS_QUAL_EDGES) begin
                  state_next = ST_GATE; // [RQ2]
               end
            end
         end
         ST_GATE: begin
            if (old_fall) begin
               gate_next = 1'b0; // [RQ14]
               state_next = ST_WAIT_NEW;
            end
         end
         ST_WAIT_NEW: begin
            // Stays here for as long as the target reference is silent [RQ16]
            if (new_fall) begin
               sel_next = ~sel_reg; // [RQ14]
               gate_next = 1'b1;
               sw_done_next = 1'b1;
               state_next = ST_WAIT_LOW;
            end
         end
         ST_WAIT_LOW: begin
            // Rising request edges are ignored until the request drops [RQ18]
            if (!req_q) begin
               state_next = ST_IDLE; // [RQ3]
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_reg <= ST_IDLE;
         sel_reg <= 1'b0; // [RQ1]
         gate_reg <= 1'b1;
         hi_cnt_reg <= 2'h0;
         sw_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sel_reg <= sel_next;
         gate_reg <= gate_next;
         hi_cnt_reg <= hi_cnt_next;
         sw_done_reg <= sw_done_next;
      end
   end

   // Register file
   reg [1:0] bw_reg;
   reg [2:0] tap_reg [0:3];
   reg [7:0] start_reg [0:3];
   reg step_pend_reg;
   reg [1:0] step_cnt_reg;
   reg step_down_reg;
   wire [1:0] ph_idx;
   wire wr_step;
   assign ph_idx = i_addr[3:2];
   assign wr_step = i_wr && (i_addr == `PRS_ADDR_STEP);

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         bw_reg <= `PRS_BW_MED; // [RQ10]
      end else if (i_wr && i_addr == `PRS_ADDR_CTRL) begin
         bw_reg <= bw_norm(i_wdata[`PRS_CTRL_BW_MSB:`PRS_CTRL_BW_LSB]); // [RQ10]
      end
   end

   // A new step request while one waits for the step clock replaces it
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         step_pend_reg <= 1'b0;
         step_cnt_reg <= 2'h0;
         step_down_reg <= 1'b0;
      end else if (wr_step) begin
         step_pend_reg <= 1'b1;
         step_cnt_reg <= i_wdata[`PRS_STEP_CNT_MSB:`PRS_STEP_CNT_LSB];
         step_down_reg <= i_wdata[`PRS_STEP_DOWN_BIT];
      end else if (step_rise) begin
         step_pend_reg <= 1'b0; // [RQ13]
      end
   end

   generate
      for (g = 0; g < `PRS_NUM_CNT; g = g + 1) begin : g_cnt
         reg [7:0] dly_reg;
         reg arm_reg;
         always @(posedge i_clk) begin
            if (!i_rst_b) begin
               tap_reg[g] <= `PRS_TAP_RST;
               start_reg[g] <= `PRS_START_RST;
            end else if (i_wr && phase_hit(i_addr) && ph_idx == g) begin
               tap_reg[g] <= i_wdata[`PRS_PH_TAP_MSB:`PRS_PH_TAP_LSB]; // [RQ11]
               start_reg[g] <= i_wdata[`PRS_PH_START_MSB:`PRS_PH_START_LSB];
            end else if (step_pend_reg && step_rise && step_cnt_reg == g) begin
               // Taps wrap through all eight phases in either direction [RQ13]
               if (step_down_reg) begin
                  tap_reg[g] <= tap_reg[g] - 3'h1;
               end else begin
                  tap_reg[g] <= tap_reg[g] + 3'h1;
               end
            end
         end
         // Counter start held off start count minus one VCO ticks [RQ12]
         always @(posedge i_clk) begin
            if (!i_rst_b) begin
               dly_reg <= 8'h00;
               arm_reg <= 1'b0;
               o_cnt_run[g] <= 1'b0;
            end else if (i_counter_restart || sw_done_reg) begin
               o_cnt_run[g] <= 1'b0;
               arm_reg <= 1'b1;
               if (start_reg[g] == 8'h00) begin
                  dly_reg <= 8'h00;
               end else begin
                  dly_reg <= start_reg[g] - 8'h01; // [RQ12]
               end
            end else if (arm_reg && i_vco_tick) begin
               if (dly_reg == 8'h00) begin
                  o_cnt_run[g] <= 1'b1;
                  arm_reg <= 1'b0;
               end else begin
                  dly_reg <= dly_reg - 8'h01;
               end
            end
         end
         always @(posedge i_clk) begin
            if (!i_rst_b) begin
               o_tap_sel[3*g+2:3*g] <= `PRS_TAP_RST;
            end else begin
               o_tap_sel[3*g+2:3*g] <= tap_reg[g]; // [RQ11]
            end
         end
      end
   endgenerate

   // Read data, one cycle after the strobe; unmapped addresses read zero
   reg [31:0] rd_next;
   always @* begin
      rd_next = 32'h00000000;
      if (i_addr == `PRS_ADDR_CTRL) begin
         rd_next[`PRS_CTRL_BW_MSB:`PRS_CTRL_BW_LSB] = bw_reg;
      end else if (i_addr == `PRS_ADDR_STATUS) begin
         rd_next[`PRS_STAT_SEL_BIT] = sel_reg;
         rd_next[`PRS_STAT_LOSS0_BIT] = loss_reg[0];
         rd_next[`PRS_STAT_LOSS1_BIT] = loss_reg[1];
         rd_next[`PRS_STAT_BUSY_BIT] = (state_reg == ST_GATE) || (state_reg == ST_WAIT_NEW);
         rd_next[`PRS_STAT_STEP_BIT] = step_pend_reg;
         rd_next[`PRS_STAT_HOLD_BIT] = ~pfd_q;
      end else if (i_addr == `PRS_ADDR_STEP) begin
         rd_next[`PRS_STEP_CNT_MSB:`PRS_STEP_CNT_LSB] = step_cnt_reg;
         rd_next[`PRS_STEP_DOWN_BIT] = step_down_reg;
      end else if (phase_hit(i_addr)) begin
         rd_next[`PRS_PH_TAP_MSB:`PRS_PH_TAP_LSB] = tap_reg[ph_idx];
         rd_next[`PRS_PH_START_MSB:`PRS_PH_START_LSB] = start_reg[ph_idx];
      end
   end

   // Outputs, all registered
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_rdata <= 32'h00000000;
         o_ref_sel <= 1'b0;
         o_ref_gate <= 1'b1;
         o_loss_primary <= 1'b0;
         o_loss_backup <= 1'b0;
         o_vco_hold <= 1'b0;
         o_out_clk_en <= 4'h0;
         o_bw_code <= `PRS_BW_MED;
      end else begin
         if (i_rd) begin
            o_rdata <= rd_next;
         end else begin
            o_rdata <= 32'h00000000;
         end
         o_ref_sel <= sel_reg; // [RQ15]
         o_ref_gate <= gate_reg; // [RQ14]
         o_loss_primary <= loss_reg[0]; // [RQ15]
         o_loss_backup <= loss_reg[1];
         o_vco_hold <= ~pfd_q; // [RQ8]
         o_out_clk_en <= q_reg[8:5]; // [RQ9]
         o_bw_code <= bw_reg; // [RQ10]
      end
   end

endmodule

// ==== hw/prs_switch_map.vh ====
// Constants for the reference switchover and phase control block
`ifndef PRS_SWITCH_MAP_VH
`define PRS_SWITCH_MAP_VH
`define PRS_ADDR_CTRL 8'h00
`define PRS_ADDR_STATUS 8'h04
`define PRS_ADDR_STEP 8'h08
`define PRS_ADDR_PHASE0 8'h10
`define PRS_ADDR_PHASE_LAST 8'h1C
`define PRS_NUM_CNT 4
`define PRS_BW_LOW 2'h0
`define PRS_BW_MED 2'h1
`define PRS_BW_HIGH 2'h2
`define PRS_CTRL_BW_LSB 0
`define PRS_CTRL_BW_MSB 1
`define PRS_STAT_SEL_BIT 0
`define PRS_STAT_LOSS0_BIT 1
`define PRS_STAT_LOSS1_BIT 2
`define PRS_STAT_BUSY_BIT 3
`define PRS_STAT_STEP_BIT 4
`define PRS_STAT_HOLD_BIT 5
`define PRS_PH_TAP_LSB 0
`define PRS_PH_TAP_MSB 2
`define PRS_PH_START_LSB 8
`define PRS_PH_START_MSB 15
`define PRS_STEP_CNT_LSB 0
`define PRS_STEP_CNT_MSB 1
`define PRS_STEP_DOWN_BIT 2
`define PRS_TAP_RST 3'h0
`define PRS_START_RST 8'h01
`define PRS_QUAL_EDGES 2'h3
`define PRS_CLK_NS 50
`define PRS_LOSS_NS 1000
`define PRS_LOSS_CYC (`PRS_LOSS_NS / `PRS_CLK_NS)
`endif

// ==== verif/prs_ctrl_props.sv ====
// Assertions on the switchover and phase control ports
`timescale 1ns/1ps
module prs_ctrl_props (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_phase_detector_enable,
   input wire [3:0] i_out_gate_en,
   input wire i_vco_tick,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire o_ref_sel,
   input wire o_ref_gate,
   input wire o_vco_hold,
   input wire [3:0] o_out_clk_en,
   input wire [1:0] o_bw_code,
   input wire [3:0] o_cnt_run
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   rst_state_a: assert property (disable iff (1'b0) !i_rst_b |=>
      !o_ref_sel && o_ref_gate && o_bw_code == 2'h1) else $error("reset state wrong");
   bw_write_a: assert property (i_wr && i_addr == 8'h00 && i_wdata[1:0] == 2'h2
      |-> ##[1:2] o_bw_code == 2'h2) else $error("bandwidth write lost");
   bw_legal_a: assert property (o_bw_code != 2'h3) else $error("bandwidth code illegal");
   sel_gated_a: assert property ($changed(o_ref_sel) |-> !$past(o_ref_gate))
      else $error("select changed while reference ungated");
   gate_back_a: assert property ($rose(o_ref_gate) |-> $changed(o_ref_sel))
      else $error("gate returned without select change");
   vco_hold_a: assert property (!i_phase_detector_enable [*6] |-> o_vco_hold)
      else $error("detector off but no hold");
   vco_run_a: assert property (i_phase_detector_enable [*6] |-> !o_vco_hold)
      else $error("detector on but hold");
   out_gate_a: assert property ($stable(i_out_gate_en) [*6] |-> o_out_clk_en == i_out_gate_en)
      else $error("output enables differ from gates");
   cnt_tick_a: assert property ($rose(o_cnt_run[0]) |-> $past(i_vco_tick) || $past(i_vco_tick, 2))
      else $error("counter started without a tick");
   cover property ($changed(o_ref_sel));
   cover property ($rose(o_vco_hold));
   cover property ($rose(o_cnt_run[2]));
endmodule
bind prs_switch_ctrl prs_ctrl_props prs_ctrl_props_inst (
   .i_clk(i_clk),
   .i_rst_b(i_rst_b),
   .i_phase_detector_enable(i_phase_detector_enable),
   .i_out_gate_en(i_out_gate_en),
   .i_vco_tick(i_vco_tick),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr),
   .o_ref_sel(o_ref_sel),
   .o_ref_gate(o_ref_gate),
   .o_vco_hold(o_vco_hold),
   .o_out_clk_en(o_out_clk_en),
   .o_bw_code(o_bw_code),
   .o_cnt_run(o_cnt_run)
);

// ==== verif/prs_ref_model.sv ====
// Reference clock sources standing in for the far-side oscillators
`timescale 1ns/1ps
module prs_ref_model (
   input wire i_clk,
   input wire i_run_primary,
   input wire i_run_backup,
   output reg o_primary = 1'b0,
   output reg o_backup = 1'b0
);
   reg [2:0] cnt_reg = 3'h0;
   // Backup runs at half the rate so qualification must follow the slower clock; the code counts the selected clock, slower or not
   always @(posedge i_clk) begin
      cnt_reg <= cnt_reg + 3'h1;
      if (i_run_primary && cnt_reg[1:0] == 2'h3) begin
         o_primary <= ~o_primary;
      end
      if (i_run_backup && cnt_reg == 3'h7) begin
         o_backup <= ~o_backup;
      end
   end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the switchover and phase control block
`timescale 1ns/1ps
module tb_top;
   reg i_clk = 1'b0;
   reg i_rst_b = 1'b0;
   reg run_p = 1'b1;
   reg run_b = 1'b1;
   reg req = 1'b0;
   reg pde = 1'b1;
   reg [3:0] gate_en = 4'hF;
   reg step_clk = 1'b0;
   reg tick = 1'b0;
   reg restart = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   wire ref_p, ref_b, sel, gate, loss_p, loss_b, hold;
   wire [31:0] rdata;
   wire [3:0] out_en, cnt_run;
   wire [1:0] bw;
   wire [11:0] tap;
   integer n_mismatch = 0;
   integer checks = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] d;
   always #25 i_clk = ~i_clk;
   prs_ref_model prs_ref_model_inst (.i_clk(i_clk), .i_run_primary(run_p),
      .i_run_backup(run_b), .o_primary(ref_p), .o_backup(ref_b));
   prs_switch_ctrl prs_switch_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_primary_ref_clock(ref_p), .i_backup_ref_clock(ref_b), .i_switch_req(req),
      .i_phase_detector_enable(pde), .i_out_gate_en(gate_en), .i_phase_step_clk(step_clk),
      .i_vco_tick(tick), .i_counter_restart(restart), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_ref_sel(sel), .o_ref_gate(gate),
      .o_loss_primary(loss_p), .o_loss_backup(loss_b), .o_vco_hold(hold),
      .o_out_clk_en(out_en), .o_bw_code(bw), .o_tap_sel(tap), .o_cnt_run(cnt_run));
   task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task cycles(input integer n);
      begin
         repeat (n) @(posedge i_clk);
         #1;
      end
   endtask
   task wr_reg(input [7:0] a, input [31:0] v);
      begin
         @(posedge i_clk);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge i_clk);
         wr <= 1'b0;
         cycles(2);
      end
   endtask
   task rd_reg(input [7:0] a);
      begin
         @(posedge i_clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge i_clk);
         rd <= 1'b0;
         #1 d = rdata;
      end
   endtask
   // Bounded so a switch that never completes cannot hang the run
   task wait_sel(input v);
      begin
         i = 0;
         while (sel !== v && i < 400) begin
            @(posedge i_clk);
            i = i + 1;
         end
         #1;
      end
   endtask
   task set_req(input v);
      begin
         @(posedge i_clk);
         req <= v;
      end
   endtask
   task pulse_step;
      begin
         @(posedge i_clk);
         step_clk <= 1'b1;
         repeat (6) @(posedge i_clk);
         step_clk <= 1'b0;
         cycles(8);
      end
   endtask
   task pulse_tick;
      begin
         @(posedge i_clk);
         tick <= 1'b1;
         @(posedge i_clk);
         tick <= 1'b0;
         cycles(2);
      end
   endtask
   task t_reset;
      begin
         chk("sel", 0, sel);
         chk("bw", 1, bw);
         chk("tap", 0, tap);
         $display("test reset done");
      end
   endtask
   task t_regs;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            wr_reg(8'h00, i);
            chk("bw", (i == 3) ? 1 : i, bw);
         end
         rd_reg(8'hFC);
         chk("unmapped", 0, d);
         rd_reg(8'h10);
         chk("phase0", 32'h100, d);
         $display("test regs done");
      end
   endtask
   task t_switch;
      begin
         set_req(1);
         wait_sel(1);
         chk("sel", 1, sel);
         chk("gate", 1, gate);
         chk("loss", 0, {loss_p, loss_b});
         set_req(0);
         cycles(40);
         set_req(1);
         cycles(6);
         set_req(0);
         cycles(150);
         chk("short", 1, sel);
         set_req(1);
         wait_sel(0);
         chk("back", 0, sel);
         cycles(200);
         chk("held", 0, sel);
         set_req(0);
         $display("test switch done");
      end
   endtask
   task t_loss;
      begin
         cycles(40);
         @(posedge i_clk);
         run_b <= 1'b0;
         cycles(40);
         chk("lossb", 1, loss_b);
         chk("lossp", 0, loss_p);
         set_req(1);
         cycles(150);
         chk("waiting", 0, sel);
         rd_reg(8'h04);
         chk("status", 32'hC, d);
         @(posedge i_clk);
         run_b <= 1'b1;
         wait_sel(1);
         chk("late", 1, sel);
         @(posedge i_clk);
         gate_en <= 4'h0;
         set_req(0);
         cycles(40);
         chk("lossb", 0, loss_b);
         chk("outen", 0, out_en);
         $display("test loss done");
      end
   endtask
   task t_hold;
      begin
         @(posedge i_clk);
         pde <= 1'b0;
         gate_en <= 4'hA;
         cycles(8);
         chk("hold", 1, hold);
         chk("outen", 4'hA, out_en);
         @(posedge i_clk);
         pde <= 1'b1;
         gate_en <= 4'h5;
         cycles(8);
         chk("hold", 0, hold);
         chk("outen", 4'h5, out_en);
         $display("test hold done");
      end
   endtask
   task t_phase;
      begin
         wr_reg(8'h08, 32'h1);
         pulse_step;
         chk("tap", 12'h008, tap);
         wr_reg(8'h08, 32'h4);
         pulse_step;
         chk("tap", 12'h00F, tap);
         wr_reg(8'h18, 32'h300);
         @(posedge i_clk);
         restart <= 1'b1;
         @(posedge i_clk);
         restart <= 1'b0;
         cycles(2);
         pulse_tick;
         pulse_tick;
         chk("run", 1, cnt_run[0]);
         chk("run2", 0, cnt_run[2]);
         pulse_tick;
         chk("run2", 1, cnt_run[2]);
         $display("test phase done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      cycles(1);
      t_reset;
      t_regs;
      t_switch;
      t_loss;
      t_hold;
      t_phase;
      tally_and_finish;
   end
endmodule
